// ==== irc_core.sv ====
// i2c port core: axi4-lite registers, slave matcher, master start engine
// Operation
// [R1] with clock hold cleared, only hold the clock once it is already low
// [R2] held clock stays low until software releases it
// [R3] general call enable acknowledges address zero regardless of own address
// [R4] all-zero write address raises the port interrupt flag
// [R5] general call in ten-bit mode leaves update-address clear
// [R6] address hold stretches after eighth fall; software picks ack and releases
// [R7] mask zero bits make received address bits don't-care
// [R8] address mask resets to all ones
// [R9] seven-bit mask covers bits 7:1, ten-bit only the low byte
// [R10] master drives pins low only when needed, otherwise releases them
// [R11] start and stop status clear on reset and when disabled
// [R12] firmware master mode: only start and stop detection in hardware
// [R13] master sets port flag on start, stop, byte, ack completion
// [R14] buffer write before start completes is dropped, write collision set
// [R15] in master mode flag follows generate bit self-clear, not detection
// [R16] master transmit: eight bits out, then one ack bit in
// [R17] master receive: eight bits in, ack sent on request
// [R18] divider waits for clock high, then reloads for the high phase
// [R19] buffer write during any sequence is dropped, write collision set
// [R20] low five command bits ignored while a start is pending
// [R21] start: time one period high, pull data low, time again, self-clear
// [R22] low lines at start or clock drop aborts with collision flag
// [R23] setting clock hold releases the held clock
`timescale 1ns/100ps
`include "irc_map.svh"
module irc_core #(
	parameter int DIV_W = 8
) (
	input  wire logic                     clock,   // 250 MHz core clock
	input  wire logic                     rst,     // async reset, active high
	input  wire irc_pkg::irc_axi_req_type axiReq,  // axi4-lite requests
	output irc_pkg::irc_axi_rsp_type      axiRsp,  // axi4-lite answers
	input  wire logic                     sclIn,   // bus clock pin level
	output logic                          sclOut,  // bus clock drive value
	output logic                          sclOeN,  // low while clock pulled
	input  wire logic                     sdaIn,   // bus data pin level
	output logic                          sdaOut,  // bus data drive value
	output logic                          sdaOeN   // low while data pulled
);
	import irc_pkg::*;

	typedef struct packed {
		irc_mst_type     mst;
		logic [7:0]      ctrl1;
		logic [7:0]      ctrl2;
		logic [7:0]      ctrl3;
		logic [7:0]      stat;
		logic [7:0]      flags;
		logic [7:0]      xferBuf;
		logic [7:0]      ownAddr;
		logic [7:0]      addrMask;
		logic [7:0]      pins;
		logic [7:0]      shift;
		logic [3:0]      bitCnt;
		logic [3:0]      nBits;
		logic            rxMode;
		logic            hiPhase;
		logic            hiRun;
		logic [1:0]      stopPh;
		logic            sclPrev;
		logic            sdaPrev;
		logic [3:0]      sCnt;
		logic [1:0]      sStage;
		logic            sActive;
		logic            sAck;
		logic            sSwAck;
		logic            uaHold;
		logic            sclRel;
		logic            sdaRel;
		logic            drvLevel;
		logic            awGot;
		logic            wGot;
		logic [7:0]      awAddr;
		logic [7:0]      wData;
		logic            wLane;
		irc_axi_rsp_type rsp;
	} irc_state_type;

	irc_state_type s_r;
	irc_state_type s_nxt;
	logic          brgLoad;
	logic          brgTick;

	if (DIV_W != 8)
		$error("irc_core: divider reload is the 8-bit address register");

	// offsets that answer okay; everything else gets slverr
	function automatic logic regKnown(input logic [7:0] a);
		case (a)
			`IRC_A_CTRL1, `IRC_A_CTRL2, `IRC_A_CTRL3, `IRC_A_STAT,
			`IRC_A_FLAGS, `IRC_A_BUF, `IRC_A_ADDR, `IRC_A_MASK,
			`IRC_A_PINS: regKnown = 1'b1;
			default:     regKnown = 1'b0;
		endcase
	endfunction

	// compare address bits from lsb upward with mask zeros as don't-care
	function automatic logic maskMatch(input logic [7:0] rx,
		input logic [7:0] own, input logic [7:0] msk, input logic lsb);
		logic [7:0] diff;
		diff = (rx ^ own) & msk;  // R7
		if (lsb)
			diff[0] = 1'b0;  // R9
		maskMatch = (diff == 8'h00);
	endfunction

	irc_rate_div #(
		.DIV_W (DIV_W)
	) u_div (
		.clock  (clock),
		.rst    (rst),
		.load   (brgLoad),
		.reload (s_r.ownAddr),
		.tick   (brgTick)
	);

	// whole next state in one place; hardware sets come after writes
	always_comb
	begin
		irc_state_type s;
		logic          doWr;
		logic          wr;
		logic [7:0]    d;
		logic          en;
		logic [3:0]    mode;
		logic          master;
		logic          slave;
		logic          bufGo;
		logic          startDet;
		logic          stopDet;
		logic          sclRise;
		logic          sclFall;
		logic          rxBit;
		logic [7:0]    rxByte;
		logic          hit;
		logic          holdReq;
		s = s_r;
		s_nxt = s_r;
		brgLoad = 1'b0;
		en = s.ctrl1[`IRC_C1_EN];
		mode = s.ctrl1[`IRC_C1_MODE];
		master = (mode == `IRC_MODE_MST);
		slave = (mode == `IRC_MODE_S7) || (mode == `IRC_MODE_S10);
		bufGo = 1'b0;
		rxByte = s.shift;
		hit = 1'b0;
		holdReq = 1'b0;
		rxBit = s.rxMode || (s.bitCnt == 4'h8);

		// axi write: address and data latched in either order
		if (axiReq.awvalid && s.rsp.awready)
		begin
			s_nxt.awGot = 1'b1;
			s_nxt.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && s.rsp.wready)
		begin
			s_nxt.wGot = 1'b1;
			s_nxt.wData = axiReq.wdata[7:0];
			s_nxt.wLane = axiReq.wstrb[0];
		end
		doWr = s.awGot && s.wGot && !s.rsp.bvalid;
		wr = doWr && s.wLane;
		d = s.wData;
		if (s.rsp.bvalid && axiReq.bready)
			s_nxt.rsp.bvalid = 1'b0;
		if (doWr)
		begin
			s_nxt.awGot = 1'b0;
			s_nxt.wGot = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			s_nxt.rsp.bresp = regKnown(s.awAddr) ? `IRC_RESP_OK
				: `IRC_RESP_ERR;
		end
		s_nxt.rsp.awready = !s_nxt.awGot && !s_nxt.rsp.bvalid;
		s_nxt.rsp.wready = !s_nxt.wGot && !s_nxt.rsp.bvalid;

		// axi read: one word answered the cycle after the address
		if (s.rsp.rvalid && axiReq.rready)
			s_nxt.rsp.rvalid = 1'b0;
		if (axiReq.arvalid && s.rsp.arready)
		begin
			s_nxt.rsp.rvalid = 1'b1;
			s_nxt.rsp.rresp = regKnown(axiReq.araddr) ? `IRC_RESP_OK
				: `IRC_RESP_ERR;
			case (axiReq.araddr)
				`IRC_A_CTRL1: s_nxt.rsp.rdata = {24'h000000, s.ctrl1};
				`IRC_A_CTRL2: s_nxt.rsp.rdata = {24'h000000, s.ctrl2};
				`IRC_A_CTRL3: s_nxt.rsp.rdata = {24'h000000, s.ctrl3};
				`IRC_A_STAT:  s_nxt.rsp.rdata = {24'h000000, s.stat};
				`IRC_A_FLAGS: s_nxt.rsp.rdata = {24'h000000, s.flags};
				`IRC_A_BUF:   s_nxt.rsp.rdata = {24'h000000, s.xferBuf};
				`IRC_A_ADDR:  s_nxt.rsp.rdata = {24'h000000, s.ownAddr};
				`IRC_A_MASK:  s_nxt.rsp.rdata = {24'h000000, s.addrMask};
				`IRC_A_PINS:  s_nxt.rsp.rdata = {30'h0, sclIn, sdaIn};
				default:      s_nxt.rsp.rdata = 32'h00000000;
			endcase
			// reading the buffer empties it
			if (axiReq.araddr == `IRC_A_BUF)
				s_nxt.stat[`IRC_ST_BF] = 1'b0;
		end
		s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

		// register writes; ack status stays hardware-owned
		if (wr)
		begin
			case (s.awAddr)
				`IRC_A_CTRL1: s_nxt.ctrl1 = d;  // R23
				`IRC_A_CTRL2:
				begin
					if (s.ctrl2[`IRC_C2_SEN])
						s_nxt.ctrl2[7:5] = d[7:5];  // R20
					else
						s_nxt.ctrl2 = d;
					s_nxt.ctrl2[`IRC_C2_ACKST] = s.ctrl2[`IRC_C2_ACKST];
				end
				`IRC_A_CTRL3: s_nxt.ctrl3 = d;
				`IRC_A_FLAGS: s_nxt.flags = s.flags & ~d;
				`IRC_A_ADDR:
				begin
					s_nxt.ownAddr = d;
					s_nxt.uaHold = 1'b0;
				end
				`IRC_A_MASK:  s_nxt.addrMask = d;
				`IRC_A_PINS:  s_nxt.pins = d;
				`IRC_A_BUF:
				begin
					// master may only load while parked between steps
					if (master && (s.mst != M_IDLE && s.mst != M_HOLD
						|| s.ctrl2[`IRC_C2_SEN] || s.ctrl2[`IRC_C2_PEN]))
						s_nxt.flags[`IRC_FL_WRITE_COLLISION_FLAG] = 1'b1;  // R14 R19
					else
					begin
						s_nxt.xferBuf = d;
						bufGo = master && (s.mst == M_HOLD);
					end
				end
				default: ;
			endcase
		end

		// bus condition detection runs in every enabled mode
		s_nxt.sclPrev = sclIn;
		s_nxt.sdaPrev = sdaIn;
		startDet = s.sclPrev && sclIn && s.sdaPrev && !sdaIn;
		stopDet = s.sclPrev && sclIn && !s.sdaPrev && sdaIn;
		sclRise = !s.sclPrev && sclIn;
		sclFall = s.sclPrev && !sclIn;
		if (startDet)
		begin
			s_nxt.stat[`IRC_ST_S] = 1'b1;
			s_nxt.stat[`IRC_ST_P] = 1'b0;
		end
		if (stopDet)
		begin
			s_nxt.stat[`IRC_ST_P] = 1'b1;
			s_nxt.stat[`IRC_ST_S] = 1'b0;
		end

		// master engine; detection raises no flag here
		if (master)  // R15
		begin
			case (s.mst)
				M_IDLE:
				begin
					s_nxt.sclRel = 1'b1;  // R10
					s_nxt.sdaRel = 1'b1;
					if (s.ctrl2[`IRC_C2_SEN])
					begin
						if (sclIn && sdaIn)
						begin
							brgLoad = 1'b1;  // R21
							s_nxt.mst = M_ST1;
						end
						else if (!sclIn && !sdaIn)
						begin
							s_nxt.flags[`IRC_FL_BCL] = 1'b1;  // R22
							s_nxt.ctrl2[`IRC_C2_SEN] = 1'b0;
						end
					end
				end
				M_ST1:
				begin
					if (brgTick && sclIn && sdaIn)
					begin
						s_nxt.sdaRel = 1'b0;  // R21
						s_nxt.stat[`IRC_ST_S] = 1'b1;
						brgLoad = 1'b1;
						s_nxt.mst = M_ST2;
					end
					else if (!sclIn || brgTick)
					begin
						s_nxt.flags[`IRC_FL_BCL] = 1'b1;  // R22
						s_nxt.ctrl2[`IRC_C2_SEN] = 1'b0;
						s_nxt.mst = M_IDLE;
					end
				end
				M_ST2:
					if (brgTick)
					begin
						s_nxt.ctrl2[`IRC_C2_SEN] = 1'b0;  // R21
						s_nxt.flags[`IRC_FL_IRQ] = 1'b1;  // R13 R15
						s_nxt.mst = M_HOLD;
					end
				M_HOLD:
				begin
					s_nxt.bitCnt = 4'h0;
					s_nxt.hiPhase = 1'b0;
					s_nxt.hiRun = 1'b0;
					if (bufGo)
					begin
						s_nxt.shift = d;  // R16
						s_nxt.nBits = 4'h9;
						s_nxt.rxMode = 1'b0;
						s_nxt.stat[`IRC_ST_BF] = 1'b1;
					end
					else if (s.ctrl2[`IRC_C2_PEN])
					begin
						s_nxt.stopPh = 2'h0;
						s_nxt.sclRel = 1'b0;
						s_nxt.sdaRel = 1'b0;
						brgLoad = 1'b1;
						s_nxt.mst = M_STOP;
					end
					else if (s.ctrl2[`IRC_C2_RCEN])
					begin
						s_nxt.nBits = 4'h8;  // R17
						s_nxt.rxMode = 1'b1;
					end
					else if (s.ctrl2[`IRC_C2_ACKEN])
					begin
						s_nxt.shift = {s.ctrl2[`IRC_C2_ACK_VALUE_SELECT], 7'h00};
						s_nxt.nBits = 4'h1;  // R17
						s_nxt.rxMode = 1'b0;
					end
					if (bufGo || (!s.ctrl2[`IRC_C2_PEN]
						&& (s.ctrl2[`IRC_C2_RCEN] || s.ctrl2[`IRC_C2_ACKEN])))
					begin
						s_nxt.sclRel = 1'b0;  // R10
						brgLoad = 1'b1;
						s_nxt.mst = M_BIT;
					end
				end
				M_BIT:
				begin
					if (!s.hiPhase)
					begin
						s_nxt.sclRel = 1'b0;
						s_nxt.sdaRel = rxBit ? 1'b1 : s.shift[7];
						if (brgTick)
						begin
							s_nxt.sclRel = 1'b1;
							s_nxt.hiPhase = 1'b1;
						end
					end
					else
					begin
						// divider idles while another device stretches
						if (!s.hiRun && sclIn)
						begin
							brgLoad = 1'b1;  // R18
							s_nxt.hiRun = 1'b1;
						end
						if (s.hiRun && brgTick)
						begin
							s_nxt.shift = {s.shift[6:0], sdaIn};
							if (s.bitCnt == 4'h8)
								s_nxt.ctrl2[`IRC_C2_ACKST] = sdaIn;  // R16
							s_nxt.bitCnt = s.bitCnt + 4'h1;
							s_nxt.hiPhase = 1'b0;
							s_nxt.hiRun = 1'b0;
							s_nxt.sclRel = 1'b0;
							if (s.bitCnt + 4'h1 == s.nBits)
							begin
								s_nxt.flags[`IRC_FL_IRQ] = 1'b1;  // R13
								s_nxt.sdaRel = 1'b1;
								s_nxt.mst = M_HOLD;
								s_nxt.ctrl2[`IRC_C2_ACKEN] = 1'b0;
								if (s.rxMode)
								begin
									s_nxt.xferBuf = {s.shift[6:0], sdaIn};
									s_nxt.stat[`IRC_ST_BF] = 1'b1;  // R17
									s_nxt.ctrl2[`IRC_C2_RCEN] = 1'b0;
								end
								else if (s.nBits == 4'h9)
									s_nxt.stat[`IRC_ST_BF] = 1'b0;
							end
							else
								brgLoad = 1'b1;
						end
					end
				end
				M_STOP:
				begin
					if (s.stopPh == 2'h0 && brgTick)
					begin
						s_nxt.sclRel = 1'b1;
						s_nxt.hiRun = 1'b0;
						s_nxt.stopPh = 2'h1;
					end
					else if (s.stopPh == 2'h1)
					begin
						if (!s.hiRun && sclIn)
						begin
							brgLoad = 1'b1;  // R18
							s_nxt.hiRun = 1'b1;
						end
						if (s.hiRun && brgTick)
						begin
							s_nxt.sdaRel = 1'b1;
							brgLoad = 1'b1;
							s_nxt.stopPh = 2'h2;
						end
					end
					else if (s.stopPh == 2'h2 && brgTick)
					begin
						s_nxt.ctrl2[`IRC_C2_PEN] = 1'b0;
						s_nxt.flags[`IRC_FL_IRQ] = 1'b1;  // R13 R15
						s_nxt.mst = M_IDLE;
					end
				end
				default: s_nxt.mst = M_IDLE;
			endcase
		end
		else
		begin
			s_nxt.mst = M_IDLE;
			s_nxt.sclRel = 1'b1;
			s_nxt.sdaRel = 1'b1;
		end

		// software owns the lines; hardware keeps only detection
		if (mode == `IRC_MODE_FWM)
		begin
			s_nxt.sclRel = !s.pins[`IRC_PN_SCL];  // R12
			s_nxt.sdaRel = !s.pins[`IRC_PN_SDA];  // R12
		end

		// slave receiver: bits in on rising clock, decide on 8th fall
		if (slave)
		begin
			if (s.sAck)
				s_nxt.sdaRel = s.sSwAck ? s.ctrl2[`IRC_C2_ACK_VALUE_SELECT] : 1'b0;
			if (s.sActive && sclRise && !s.sAck)
			begin
				s_nxt.shift = {s.shift[6:0], sdaIn};
				s_nxt.sCnt = s.sCnt + 4'h1;
			end
			if (s.sActive && sclFall)
			begin
				if (s.sAck)
				begin
					s_nxt.sAck = 1'b0;
					s_nxt.sdaRel = 1'b1;
					s_nxt.sCnt = 4'h0;
				end
				else if (s.sCnt == 4'h8)
				begin
					s_nxt.sCnt = 4'h0;
					if (s.sStage == 2'h0)
					begin
						s_nxt.stat[`IRC_ST_RW] = rxByte[0];
						s_nxt.stat[`IRC_ST_DA] = 1'b0;
						if (s.ctrl2[`IRC_C2_GENERAL_CALL_ENABLE]
							&& rxByte == `IRC_GC_ADDR)
						begin
							hit = 1'b1;  // R3 R4 R5
							s_nxt.sStage = 2'h2;
						end
						else if (mode == `IRC_MODE_S10)
						begin
							// high byte compared exactly, mask unused
							hit = (rxByte[7:3] == `IRC_TEN_HDR)
								&& (rxByte[2:1] == s.ownAddr[2:1]);  // R9
							s_nxt.stat[`IRC_ST_UA] = hit;
							s_nxt.uaHold = hit;
							s_nxt.sStage = 2'h1;
						end
						else
						begin
							hit = maskMatch(rxByte, s.ownAddr,
								s.addrMask, 1'b1);  // R7 R9
							s_nxt.sStage = 2'h2;
						end
					end
					else if (s.sStage == 2'h1)
					begin
						hit = maskMatch(rxByte, s.ownAddr,
							s.addrMask, 1'b0);  // R9
						// low byte mismatch still interrupts so software
						// can put the high address back
						s_nxt.stat[`IRC_ST_UA] = 1'b1;
						s_nxt.flags[`IRC_FL_IRQ] = 1'b1;
						s_nxt.uaHold = 1'b1;
						s_nxt.sStage = 2'h2;
					end
					else
					begin
						hit = 1'b1;
						s_nxt.stat[`IRC_ST_DA] = 1'b1;
					end
					// foreign addresses get no ack and no flag, except a ten-bit low byte mismatch, which still flags
					if (hit)
					begin
						s_nxt.flags[`IRC_FL_IRQ] = 1'b1;  // R4
						s_nxt.xferBuf = rxByte;
						s_nxt.stat[`IRC_ST_BF] = 1'b1;
						s_nxt.sAck = 1'b1;
						s_nxt.sSwAck = s.ctrl3[`IRC_C3_ADDRESS_HOLD_ENABLE]
							&& (s.sStage != 2'h2);  // R6
						if (s.ctrl3[`IRC_C3_ADDRESS_HOLD_ENABLE] && s.sStage != 2'h2)
						begin
							s_nxt.ctrl1[`IRC_C1_CKP] = 1'b0;  // R6
							s_nxt.sdaRel = s.ctrl2[`IRC_C2_ACK_VALUE_SELECT];
						end
						else
							s_nxt.sdaRel = 1'b0;  // R3
					end
					else
						s_nxt.sActive = 1'b0;
				end
			end
			if (startDet)
			begin
				s_nxt.sActive = 1'b1;
				s_nxt.sCnt = 4'h0;
				s_nxt.sStage = 2'h0;
				s_nxt.sAck = 1'b0;
				s_nxt.sdaRel = 1'b1;
			end
			if (stopDet)
			begin
				s_nxt.sActive = 1'b0;
				s_nxt.sAck = 1'b0;
				s_nxt.sdaRel = 1'b1;
			end
			// never pull a high clock: join only once it is low
			holdReq = !s_nxt.ctrl1[`IRC_C1_CKP] || s.uaHold;
			s_nxt.sclRel = !(holdReq && (!s.sclRel || !sclIn));  // R1 R2
		end
		else
		begin
			s_nxt.sActive = 1'b0;
			s_nxt.sAck = 1'b0;
			s_nxt.uaHold = 1'b0;
		end

		// disabled port forgets bus state and lets go of both lines
		if (!en)
		begin
			s_nxt.stat[`IRC_ST_S] = 1'b0;  // R11
			s_nxt.stat[`IRC_ST_P] = 1'b0;  // R11
			s_nxt.mst = M_IDLE;
			s_nxt.sActive = 1'b0;
			s_nxt.sAck = 1'b0;
			s_nxt.uaHold = 1'b0;
			s_nxt.sclRel = 1'b1;
			s_nxt.sdaRel = 1'b1;
			brgLoad = 1'b0;
		end
	end

	// one register stage for the whole state
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.mst <= M_IDLE;
			s_r.ctrl1 <= `IRC_C1_RST;
			s_r.addrMask <= `IRC_MASK_RST;  // R8
			s_r.sclPrev <= 1'b1;
			s_r.sdaPrev <= 1'b1;
			s_r.sclRel <= 1'b1;
			s_r.sdaRel <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// open-drain pins: drive value is the constant low level
	assign axiRsp = s_r.rsp;
	assign sclOut = s_r.drvLevel;
	assign sdaOut = s_r.drvLevel;
	assign sclOeN = s_r.sclRel;
	assign sdaOeN = s_r.sdaRel;
endmodule

// ==== irc_map.svh ====
// register offsets, field positions and reset values of the i2c core
`ifndef IRC_MAP_SVH
`define IRC_MAP_SVH
`define IRC_A_CTRL1   8'h00
`define IRC_A_CTRL2   8'h04
`define IRC_A_CTRL3   8'h08
`define IRC_A_STAT    8'h0c
`define IRC_A_FLAGS   8'h10
`define IRC_A_BUF     8'h14
`define IRC_A_ADDR    8'h18
`define IRC_A_MASK    8'h1c
`define IRC_A_PINS    8'h20
`define IRC_C1_EN     0
`define IRC_C1_CKP    1
`define IRC_C1_MODE   5:2
`define IRC_C2_SEN    0
`define IRC_C2_PEN    2
`define IRC_C2_RCEN   3
`define IRC_C2_ACKEN  4
`define IRC_C2_ACK_VALUE_SELECT  5
`define IRC_C2_ACKST  6
`define IRC_C2_GENERAL_CALL_ENABLE   7
`define IRC_C2_CMDS   4:0
`define IRC_C3_ADDRESS_HOLD_ENABLE   0
`define IRC_ST_BF     0
`define IRC_ST_UA     1
`define IRC_ST_S      2
`define IRC_ST_P      3
`define IRC_ST_RW     4
`define IRC_ST_DA     5
`define IRC_FL_IRQ    0
`define IRC_FL_WRITE_COLLISION_FLAG   1
`define IRC_FL_BCL    2
`define IRC_PN_SDA    0
`define IRC_PN_SCL    1
`define IRC_MODE_S7   4'h6
`define IRC_MODE_S10  4'h7
`define IRC_MODE_MST  4'h8
`define IRC_MODE_FWM  4'hb
`define IRC_C1_RST    8'h02
`define IRC_MASK_RST  8'hff
`define IRC_GC_ADDR   8'h00
`define IRC_TEN_HDR   5'h1e
`define IRC_RESP_OK   2'h0
`define IRC_RESP_ERR  2'h2
`endif

// ==== irc_pkg.sv ====
// types shared by the i2c core files
package irc_pkg;
	typedef enum logic [5:0] {
		M_IDLE = 6'h01,
		M_ST1  = 6'h02,
		M_ST2  = 6'h04,
		M_HOLD = 6'h08,
		M_BIT  = 6'h10,
		M_STOP = 6'h20
	} irc_mst_type;
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} irc_axi_req_type;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} irc_axi_rsp_type;
endpackage

// ==== irc_rate_div.sv ====
// reloadable down counter that times one bus clock phase
`timescale 1ns/100ps
module irc_rate_div #(
	parameter int DIV_W = 8
) (
	input  wire logic             clock,   // core clock
	input  wire logic             rst,     // async reset, active high
	input  wire logic             load,    // reload and start counting
	input  wire logic [DIV_W-1:0] reload,  // period minus one
	output logic                  tick     // period elapsed
);
	logic [DIV_W-1:0] cnt_r;
	logic             run_r;

	// a period is reload+1 cycles, so zero still gives one cycle
	if (DIV_W < 1 || DIV_W > 16)
		$error("irc_rate_div: DIV_W out of range");

	assign tick = run_r && (cnt_r == '0);

	// count stops after the timeout until the next load
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= '0;
			run_r <= 1'b0;
		end
		else if (load)
		begin
			cnt_r <= reload;
			run_r <= 1'b1;
		end
		else if (tick)
			run_r <= 1'b0;
		else if (run_r)
			cnt_r <= cnt_r - 1'b1;
	end
endmodule

// ==== irc_core_assertions.sv ====
// port assertions for the i2c core
`timescale 1ns/100ps
module irc_core_assertions (
	input wire logic                     clock,  // core clock
	input wire logic                     rst,    // async reset
	input wire irc_pkg::irc_axi_req_type axiReq, // bus requests
	input wire irc_pkg::irc_axi_rsp_type axiRsp, // bus answers
	input wire logic                     sclIn,  // clock wire
	input wire logic                     sclOut, // clock drive
	input wire logic                     sclOeN, // clock pull
	input wire logic                     sdaIn,  // data wire
	input wire logic                     sdaOut, // data drive
	input wire logic                     sdaOeN  // data pull
);
	import irc_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// open drain: a high would fight the pull-up
	AST_DRIVE_ZERO: assert property (!sclOut && !sdaOut)
		else $error("pin drive not zero");
	// data pulled under a free high clock: clock was already high
	AST_START_EDGE: assert property (
		$fell(sdaOeN) && sclOeN && sclIn |-> $past(sclIn, 2))
		else $error("data pulled on fresh clock high");
	AST_W_LAT: assert property (axiReq.awvalid && axiRsp.awready &&
		axiReq.wvalid && axiRsp.wready |-> ##[1:2] axiRsp.bvalid)
		else $error("write answer late");
	AST_R_LAT: assert property (axiReq.arvalid && axiRsp.arready
		|=> axiRsp.rvalid) else $error("read answer late");
	AST_R_ERR: assert property (axiRsp.rvalid && axiRsp.rresp != 2'h0
		|-> axiRsp.rdata == 32'h0) else $error("error read has data");
	AST_R_WIDTH: assert property (axiRsp.rvalid
		|-> axiRsp.rdata[31:8] == 24'h0) else $error("upper bits set");
	AST_W_BUSY: assert property (axiRsp.bvalid
		|-> !axiRsp.awready && !axiRsp.wready)
		else $error("ready during write answer");
	AST_R_BUSY: assert property (axiRsp.rvalid |-> !axiRsp.arready)
		else $error("ready during read answer");
endmodule
bind irc_core irc_core_assertions i_irc_core_assertions (
	.clock(clock), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
	.sclIn(sclIn), .sclOut(sclOut), .sclOeN(sclOeN),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN));

// ==== irc_bus_model.sv ====
// other bus parties: pull-ups and a bit-banging master
`timescale 1ns/100ps
module irc_bus_model (
	input  wire logic clock,      // core clock
	input  wire logic coreSclOeN, // core pulls clock
	input  wire logic coreSdaOeN, // core pulls data
	output logic      sclLine,    // resolved clock wire
	output logic      sdaLine     // resolved data wire
);
	logic pullScl = 1'b0;
	logic pullSda = 1'b0;
	// wired and; a released line goes to its pull-up
	assign sclLine = coreSclOeN & ~pullScl;
	assign sdaLine = coreSdaOeN & ~pullSda;
	// set both lines after an edge, hold a quarter bit
	task automatic drive(input logic c, input logic d);
		@(posedge clock);
		pullScl <= ~c;
		pullSda <= ~d;
		repeat (4) @(posedge clock);
	endtask
	// release clock; a stretching slave makes us wait
	task automatic rise(input logic d);
		drive(1'b1, d);
		while (!sclLine)
			@(posedge clock);
		repeat (4) @(posedge clock);
	endtask
	// start, address byte msb first, ack clock, stop
	task automatic frame(input logic [7:0] b, output logic ack);
		drive(1'b1, 1'b1);
		drive(1'b1, 1'b0);
		for (int i = 7; i >= 0; i--)
		begin
			drive(1'b0, b[i]);
			rise(b[i]);
		end
		drive(1'b0, 1'b1);
		rise(1'b1);
		ack = ~sdaLine;
		drive(1'b0, 1'b1);
		drive(1'b0, 1'b0);
		rise(1'b0);
		drive(1'b1, 1'b1);
	endtask
endmodule

// ==== tb_i2c_slave_master_core.sv ====
// self-checking bench for the i2c core
`timescale 1ns/100ps
`include "irc_map.svh"
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("CHECK FAILED %0t got %h want %h", $time, g, e); \
		end \
	end
module tb_i2c_slave_master_core;
	import irc_pkg::*;
	typedef struct packed {
		logic       general_call_enable;
		logic [7:0] mask;
		logic [7:0] addr;
		logic       ack;
	} irc_row_type;
	logic            clock;
	logic            rst;
	irc_axi_req_type axiReq;
	irc_axi_rsp_type axiRsp;
	logic            sclIn;
	logic            sdaIn;
	logic            sclOeN;
	logic            sdaOeN;
	logic [31:0]     rd;
	logic [1:0]      resp;
	logic            ack;
	int              bad_count;
	int              num_checks;
	// own address 0x55: plain, masked bit, general call
	irc_row_type rows [5] = '{
		'{1'b0, 8'hff, 8'haa, 1'b1}, '{1'b0, 8'hff, 8'ha8, 1'b0},
		'{1'b0, 8'hfd, 8'ha8, 1'b1}, '{1'b1, 8'hff, 8'h00, 1'b1},
		'{1'b0, 8'hff, 8'h00, 1'b0}};
	irc_core i_irc_core (.clock(clock), .rst(rst), .axiReq(axiReq),
		.axiRsp(axiRsp), .sclIn(sclIn), .sclOut(), .sclOeN(sclOeN),
		.sdaIn(sdaIn), .sdaOut(), .sdaOeN(sdaOeN));
	irc_bus_model i_irc_bus_model (.clock(clock), .coreSclOeN(sclOeN),
		.coreSdaOeN(sdaOeN), .sclLine(sclIn), .sdaLine(sdaIn));
	// 250 MHz core clock
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// one access; answers sampled at the negedge before the taking edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		logic aw, w, ar, done;
		@(posedge clock);
		axiReq.awvalid <= wr;
		axiReq.wvalid <= wr;
		axiReq.bready <= wr;
		axiReq.arvalid <= !wr;
		axiReq.rready <= !wr;
		axiReq.awaddr <= a;
		axiReq.araddr <= a;
		axiReq.wdata <= {24'h0, d};
		axiReq.wstrb <= 4'hf;
		done = 1'b0;
		while (!done)
		begin
			@(negedge clock);
			aw = axiRsp.awready & axiReq.awvalid;
			w = axiRsp.wready & axiReq.wvalid;
			ar = axiRsp.arready & axiReq.arvalid;
			done = wr ? axiRsp.bvalid : axiRsp.rvalid;
			rd = axiRsp.rdata;
			resp = wr ? axiRsp.bresp : axiRsp.rresp;
			@(posedge clock);
			if (aw) axiReq.awvalid <= 1'b0;
			if (w) axiReq.wvalid <= 1'b0;
			if (ar) axiReq.arvalid <= 1'b0;
		end
		axiReq.bready <= 1'b0;
		axiReq.rready <= 1'b0;
	endtask
	// read a register and compare the masked value
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 8'h0);
		`CHK(rd & m, e)
	endtask
	task automatic doReset();
		@(posedge clock);
		rst <= 1'b1;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// whole run needs well under 20k cycles
	initial
	begin
		#200000;
		bad_count++;
		summarize();
	end
	initial
	begin
		axiReq = '0;
		rst = 1'b1;
		bad_count = 0;
		num_checks = 0;
		doReset();
		// seven-bit slave, clock released
		bus(1'b1, `IRC_A_ADDR, 8'haa);
		bus(1'b1, `IRC_A_CTRL1, 8'h1b);
		foreach (rows[i])
		begin
			bus(1'b1, `IRC_A_CTRL2, {rows[i].general_call_enable, 7'h0});
			bus(1'b1, `IRC_A_MASK, rows[i].mask);
			i_irc_bus_model.frame(rows[i].addr, ack);
			`CHK(ack, rows[i].ack)
			rdc(`IRC_A_FLAGS, 32'h1, {31'h0, rows[i].ack});
			bus(1'b0, `IRC_A_BUF, 8'h0);
			bus(1'b1, `IRC_A_FLAGS, 8'h07);
		end
		// stop seen, then cleared by disabling
		rdc(`IRC_A_STAT, 32'h8, 32'h8);
		bus(1'b1, `IRC_A_CTRL1, 8'h1a);
		rdc(`IRC_A_STAT, 32'hc, 32'h0);
		// hold bit cleared: clock caught only once pulled elsewhere
		bus(1'b1, `IRC_A_CTRL1, 8'h19);
		repeat (8) @(negedge clock);
		`CHK(sclOeN, 1'b1)
		i_irc_bus_model.drive(1'b0, 1'b1);
		repeat (4) @(negedge clock);
		`CHK(sclOeN, 1'b0)
		i_irc_bus_model.drive(1'b1, 1'b1);
		@(negedge clock);
		`CHK(sclIn, 1'b0)
		bus(1'b1, `IRC_A_CTRL1, 8'h1b);
		repeat (4) @(negedge clock);
		`CHK(sclIn, 1'b1)
		// reset mid-run over a dirty mask
		bus(1'b1, `IRC_A_MASK, 8'h0f);
		doReset();
		rdc(`IRC_A_MASK, 32'hffffffff, 32'hff);
		rdc(`IRC_A_CTRL1, 32'hffffffff, 32'h02);
		rdc(`IRC_A_STAT, 32'hffffffff, 32'h0);
		rdc(8'h24, 32'hffffffff, 32'h0);
		`CHK(resp, 2'h2)
		bus(1'b1, 8'h24, 8'h0);
		`CHK(resp, 2'h2)
		// master start, 32-cycle phase; queued work must bounce
		bus(1'b1, `IRC_A_ADDR, 8'h1f);
		bus(1'b1, `IRC_A_CTRL1, 8'h23);
		bus(1'b1, `IRC_A_CTRL2, 8'h01);
		bus(1'b1, `IRC_A_BUF, 8'h5a);
		bus(1'b1, `IRC_A_CTRL2, 8'h05);
		rdc(`IRC_A_CTRL2, 32'h7, 32'h1);
		rdc(`IRC_A_FLAGS, 32'h3, 32'h2);
		while (sdaOeN)
			@(negedge clock);
		`CHK(sclOeN, 1'b1)
		rdc(`IRC_A_STAT, 32'h4, 32'h4);
		do
			bus(1'b0, `IRC_A_CTRL2, 8'h0);
		while (rd[0]);
		`CHK(sdaOeN, 1'b0)
		rdc(`IRC_A_FLAGS, 32'h3, 32'h3);
		rdc(`IRC_A_BUF, 32'hffffffff, 32'h0);
		// both lines low at start: abort with bus collision
		doReset();
		bus(1'b1, `IRC_A_CTRL1, 8'h23);
		i_irc_bus_model.drive(1'b0, 1'b0);
		bus(1'b1, `IRC_A_CTRL2, 8'h01);
		rdc(`IRC_A_CTRL2, 32'h1, 32'h0);
		rdc(`IRC_A_FLAGS, 32'h4, 32'h4);
		`CHK(sdaOeN, 1'b1)
		i_irc_bus_model.drive(1'b1, 1'b1);
		// firmware master: software pulls data, start still detected
		bus(1'b1, `IRC_A_CTRL1, 8'h2f);
		bus(1'b1, `IRC_A_PINS, 8'h01);
		repeat (4) @(negedge clock);
		`CHK(sdaOeN, 1'b0)
		rdc(`IRC_A_STAT, 32'h4, 32'h4);
		summarize();
	end
endmodule
